// ---- rtl/tcbs_pkg.sv ----
package tcbs_pkg;
  // Slot and pause lengths converted to cycles of core_clk
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned CHARGE_SLOT_MS = 1000;
  localparam int unsigned MEASURE_MS = 1;
  localparam int unsigned CHARGE_CYCLES = CLK_HZ / 1000 * CHARGE_SLOT_MS;
  localparam int unsigned MEASURE_CYCLES = CLK_HZ / 1000 * MEASURE_MS;
  localparam int unsigned BREAK_CYCLES = 1;
  // Imbalance threshold in millivolts
  localparam int unsigned THRESHOLD_MV = 30;
  localparam int unsigned MV_WIDTH = 13;
  localparam int unsigned CNT_WIDTH = 25;

  // Reset values of outputs
  localparam logic [3:0] SW_RESET = 4'h0;

  typedef enum logic [1:0] {
    TCBS_LOWER, TCBS_BALANCED, TCBS_UPPER
  } tcbs_decision_t;

  typedef enum logic [1:0] {
    TCBS_MEASURE, TCBS_BREAK, TCBS_CHARGE
  } tcbs_phase_t;

  // Four path switches, one = closed
  typedef struct packed {
    logic path_switch_one;
    logic path_switch_two;
    logic path_switch_three;
    logic path_switch_four;
  } tcbs_switch_t;

  // Two indicator outputs
  typedef struct packed {
    logic upper_cell_indicator;
    logic lower_cell_indicator;
  } tcbs_ind_t;
endpackage

// ---- rtl/tcbs_sequencer.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - Difference above threshold means unbalanced; lower-voltage cell is charged first.
// - Unbalanced: repeat 1 s charge then 1 ms pause measuring both cells.
// - Upper above lower by threshold: charge lower, close switches two and four.
// - Lower-cell indicator high in charge-lower state, low otherwise except measurement.
// - Lower above upper by threshold: charge upper, close switches one and three.
// - Upper-cell indicator high in charge-upper state, low otherwise except measurement.
// - Balanced: alternate cells, 1 s charge each, 1 ms measure between slots.
// - During every measurement pause both indicators are high together.
// - Imbalance threshold is 30 mV.
module tcbs_sequencer
  import tcbs_pkg::*;
#(
  parameter int unsigned CHARGE_CNT = CHARGE_CYCLES,
  parameter int unsigned MEASURE_CNT = MEASURE_CYCLES
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [MV_WIDTH-1:0] upper_cell_voltage,
  input wire logic [MV_WIDTH-1:0] lower_cell_voltage,
  output tcbs_switch_t path_sw,
  output tcbs_ind_t indicator,
  output logic measuring,
  output tcbs_decision_t decision
);

  ////////////////////////////////////////////////////////////////////////////
  // Voltage inputs come from a converter outside this clock: two flops each
  logic [MV_WIDTH-1:0] up_s1_r, up_s2_r, lo_s1_r, lo_s2_r;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      up_s1_r <= '0;
      up_s2_r <= '0;
      lo_s1_r <= '0;
      lo_s2_r <= '0;
    end else begin
      up_s1_r <= upper_cell_voltage;
      up_s2_r <= up_s1_r;
      lo_s1_r <= lower_cell_voltage;
      lo_s2_r <= lo_s1_r;
    end
  end

  function automatic tcbs_decision_t classify(input logic [MV_WIDTH-1:0] up,
                                              input logic [MV_WIDTH-1:0] lo);
    logic [MV_WIDTH:0] th;
    th = (MV_WIDTH+1)'(THRESHOLD_MV);
    if ({1'b0, up} > {1'b0, lo} + th) classify = TCBS_LOWER;
    else if ({1'b0, lo} > {1'b0, up} + th) classify = TCBS_UPPER;
    else classify = TCBS_BALANCED;
  endfunction

  function automatic tcbs_switch_t pair_for(input logic charge_lower);
    pair_for = charge_lower ? 4'b0101 : 4'b1010;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Phase sequencer: measure, break-before-make, charge slot
  tcbs_phase_t phase_r;
  logic [CNT_WIDTH-1:0] cnt_r;
  tcbs_decision_t dec_r;
  logic alt_lower_r;
  logic tgt_lower_r;
  logic [CNT_WIDTH-1:0] charge_last, measure_last;
  tcbs_decision_t dec_nxt;

  // Decision offered by the synchronised voltages; taken only at pause end
  assign dec_nxt = classify(up_s2_r, lo_s2_r);

  assign charge_last = CNT_WIDTH'(CHARGE_CNT - 1);
  assign measure_last = CNT_WIDTH'(MEASURE_CNT - 1);

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase_r <= TCBS_MEASURE;
      cnt_r <= '0;
      dec_r <= TCBS_BALANCED;
      alt_lower_r <= 1'b0;
      tgt_lower_r <= 1'b1;
    end else begin
      unique case (phase_r)
        TCBS_MEASURE: begin
          if (cnt_r == measure_last) begin
            dec_r <= dec_nxt;
            cnt_r <= '0;
            phase_r <= TCBS_BREAK;
            unique case (dec_nxt)
              TCBS_LOWER: tgt_lower_r <= 1'b1;
              TCBS_UPPER: tgt_lower_r <= 1'b0;
              TCBS_BALANCED: begin
                tgt_lower_r <= alt_lower_r;
                alt_lower_r <= ~alt_lower_r;
              end
              default: tgt_lower_r <= tgt_lower_r;
            endcase
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        TCBS_BREAK: begin
          phase_r <= TCBS_CHARGE;
          cnt_r <= '0;
        end
        TCBS_CHARGE: begin
          if (cnt_r == charge_last) begin
            phase_r <= TCBS_MEASURE;
            cnt_r <= '0;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      path_sw <= SW_RESET;
      indicator <= '0;
      measuring <= 1'b0;
      decision <= TCBS_BALANCED;
    end else begin
      decision <= dec_r;
      measuring <= (phase_r == TCBS_MEASURE);
      if (phase_r == TCBS_CHARGE) begin
        path_sw <= pair_for(tgt_lower_r);
      end else begin
        path_sw <= SW_RESET;
      end
      if (phase_r == TCBS_MEASURE) begin
        indicator <= 2'b11;
      end else begin
        indicator.lower_cell_indicator <= (dec_r == TCBS_LOWER);
        indicator.upper_cell_indicator <= (dec_r == TCBS_UPPER);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  logic [3:0] sw_bits;
  assign sw_bits = path_sw;

  // Helper counters: length of the current closed run and of the current pause
  logic [CNT_WIDTH-1:0] closed_run_r;
  logic [CNT_WIDTH-1:0] pause_run_r;
  logic [CNT_WIDTH-1:0] charge_full, measure_full;

  assign charge_full = CNT_WIDTH'(CHARGE_CNT);
  assign measure_full = CNT_WIDTH'(MEASURE_CNT);

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      closed_run_r <= '0;
      pause_run_r <= '0;
    end else begin
      closed_run_r <= (sw_bits != 4'h0) ? closed_run_r + 1'b1 : '0;
      pause_run_r <= measuring ? pause_run_r + 1'b1 : '0;
    end
  end

  slot_length_a: assert property (
    (sw_bits == 4'h0 && closed_run_r != '0) |-> closed_run_r == charge_full)
    else $error("charge slot length wrong");
  slot_max_a: assert property (
    closed_run_r <= charge_full)
    else $error("charge slot too long");
  pause_length_a: assert property (
    (!measuring && pause_run_r != '0) |-> pause_run_r == measure_full)
    else $error("measurement pause length wrong");
  gap_open_a: assert property (
    $fell(measuring) |-> sw_bits == 4'h0)
    else $error("switch closed right after pause");
  decision_move_a: assert property (
    $changed(decision) |-> $fell(measuring))
    else $error("decision moved outside pause end");
  balanced_ind_a: assert property (
    (!measuring && decision == TCBS_BALANCED) |-> indicator == 2'b00)
    else $error("indicator high in balanced state");

  no_short_a: assert property (
    !(sw_bits[3] && sw_bits[2]) && !(sw_bits[1] && sw_bits[0]))
    else $error("both pairs closed");
  bbm_gap_a: assert property (
    (sw_bits != 4'h0 && $past(sw_bits) != 4'h0) |-> sw_bits == $past(sw_bits))
    else $error("pair changed without open gap");
  measure_ind_a: assert property (
    measuring |-> indicator == 2'b11)
    else $error("indicators not both high in measure");
  measure_open_a: assert property (
    measuring |-> sw_bits == 4'h0)
    else $error("switch closed during measure");
  lower_pair_a: assert property (
    (sw_bits != 4'h0 && decision == TCBS_LOWER) |-> sw_bits == 4'b0101)
    else $error("wrong pair for lower cell");
  upper_pair_a: assert property (
    (sw_bits != 4'h0 && decision == TCBS_UPPER) |-> sw_bits == 4'b1010)
    else $error("wrong pair for upper cell");
  lower_ind_a: assert property (
    !measuring |-> indicator.lower_cell_indicator == (decision == TCBS_LOWER))
    else $error("lower indicator wrong");
  upper_ind_a: assert property (
    !measuring |-> indicator.upper_cell_indicator == (decision == TCBS_UPPER))
    else $error("upper indicator wrong");
  decide_at_end_a: assert property (
    $changed(dec_r) |-> $past(phase_r) == TCBS_MEASURE)
    else $error("decision changed outside pause end");
  alternate_a: assert property (
    (phase_r == TCBS_MEASURE && $past(phase_r) == TCBS_CHARGE && dec_r == TCBS_BALANCED
     && $past(dec_r) == TCBS_BALANCED) |-> alt_lower_r != $past(tgt_lower_r))
    else $error("balanced slots not alternating");

  cov_lower_c: cover property (decision == TCBS_LOWER && sw_bits == 4'b0101);
  cov_upper_c: cover property (decision == TCBS_UPPER && sw_bits == 4'b1010);
  cov_bal_c: cover property (decision == TCBS_BALANCED && sw_bits != 4'h0);
  cov_bal_lower_c: cover property (decision == TCBS_BALANCED && sw_bits == 4'b0101);
  cov_measure_c: cover property ($rose(measuring));
endmodule

// ---- sim/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  import tcbs_pkg::*;
  localparam int unsigned CH = 20;
  localparam int unsigned MS = 5;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic load = 1'b1;
  logic prev_bal = 1'b0;
  logic [MV_WIDTH-1:0] load_up = 13'h0E74;
  logic [MV_WIDTH-1:0] load_lo = 13'h0E24;
  logic [MV_WIDTH-1:0] up_v, lo_v;
  logic [MV_WIDTH-1:0] up_tab [4] = '{13'h0E10, 13'h0E2E, 13'h0E2F, 13'h0E10};
  logic [MV_WIDTH-1:0] lo_tab [4] = '{13'h0E10, 13'h0E10, 13'h0E10, 13'h0E2F};
  tcbs_switch_t path_sw, prev_pair;
  tcbs_ind_t indicator;
  logic measuring;
  tcbs_decision_t decision;
  int n_mismatch = 0, total_checks = 0, cycles = 0;
  always #20 core_clk = ~core_clk;
  tcbs_sequencer #(.CHARGE_CNT(CH), .MEASURE_CNT(MS)) tcbs_sequencer_i (
    .core_clk(core_clk), .sys_rst(sys_rst), .upper_cell_voltage(up_v),
    .lower_cell_voltage(lo_v), .path_sw(path_sw), .indicator(indicator),
    .measuring(measuring), .decision(decision));
  tcbs_cell_model tcbs_cell_model_i (.core_clk(core_clk), .path_sw(path_sw), .load(load),
    .load_up(load_up), .load_lo(load_lo), .upper_cell_voltage(up_v), .lower_cell_voltage(lo_v));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic do_reset();
    @(posedge core_clk);
    sys_rst <= 1'b1;
    tick();
    check(path_sw, 8'h00);
    check({measuring, indicator}, 8'h00);
    prev_bal = 1'b0;
    @(posedge core_clk);
    sys_rst <= 1'b0;
    load <= 1'b0;
  endtask
  // One pause and charge slot, judged from the voltages the cells show
  task automatic run_slot(input logic [MV_WIDTH-1:0] up, input logic [MV_WIDTH-1:0] lo,
                          input logic doit);
    int n;
    tcbs_decision_t exp;
    tcbs_switch_t pair;
    n = 0;
    load_up = up;
    load_lo = lo;
    while (measuring !== 1'b1) tick();
    while (measuring === 1'b1) begin
      check({indicator, path_sw}, 8'h30);
      n++;
      tick();
    end
    check(n, MS);
    check(path_sw, 8'h00);
    if (up_v > lo_v + THRESHOLD_MV) exp = TCBS_LOWER;
    else if (lo_v > up_v + THRESHOLD_MV) exp = TCBS_UPPER;
    else exp = TCBS_BALANCED;
    tick();
    pair = path_sw;
    check(decision, exp);
    if (exp == TCBS_LOWER) check({indicator, pair}, 8'h15);
    else if (exp == TCBS_UPPER) check({indicator, pair}, 8'h2A);
    else if (prev_bal) check({indicator, pair}, {4'h0, ~prev_pair});
    else check(pair == 4'h5 || pair == 4'hA, 8'h01);
    prev_bal = (exp == TCBS_BALANCED);
    prev_pair = pair;
    n = 0;
    // New voltages arrive early in the slot and must not move the pair
    while (measuring !== 1'b1) begin
      if (path_sw === pair) n++;
      load = doit && n == 2;
      tick();
    end
    load = 1'b0;
    check(n, CH);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    do_reset();
    repeat (8) run_slot(13'h0000, 13'h0000, 1'b0);
    for (int i = 0; i < 4; i++) begin
      run_slot(up_tab[i], lo_tab[i], 1'b1);
      run_slot(13'h0000, 13'h0000, 1'b0);
      run_slot(13'h0000, 13'h0000, 1'b0);
    end
    do_reset();
    repeat (2) run_slot(13'h0000, 13'h0000, 1'b0);
    end_of_test();
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_mismatch++;
      end_of_test();
    end
  end
endmodule

// ---- sim/tcbs_cell_model.sv ----
`timescale 1ns/1ps
module tcbs_cell_model
  import tcbs_pkg::*;
#(
  parameter int unsigned STEP_MV = 10
) (
  input wire logic core_clk,
  input wire tcbs_switch_t path_sw,
  input wire logic load,
  input wire logic [MV_WIDTH-1:0] load_up,
  input wire logic [MV_WIDTH-1:0] load_lo,
  output logic [MV_WIDTH-1:0] upper_cell_voltage,
  output logic [MV_WIDTH-1:0] lower_cell_voltage
);
  tcbs_switch_t prev_r;
  // The charged cell gains one step as its slot begins
  always_ff @(posedge core_clk) begin
    prev_r <= path_sw;
    if (load) begin
      upper_cell_voltage <= load_up;
      lower_cell_voltage <= load_lo;
    end else if (prev_r == 4'h0 && path_sw == 4'h5) begin
      lower_cell_voltage <= lower_cell_voltage + 13'(STEP_MV);
    end else if (prev_r == 4'h0 && path_sw == 4'hA) begin
      upper_cell_voltage <= upper_cell_voltage + 13'(STEP_MV);
    end
  end
endmodule
